// ---- hw/sui_cfg.svh ----
`ifndef SUI_CFG_SVH
`define SUI_CFG_SVH

// Register byte offsets on the plain register port
`define SUI_OFS_INSTR 8'h00
`define SUI_OFS_WREG 8'h04
`define SUI_OFS_BANK_SELECT_REGISTER 8'h08
`define SUI_OFS_STATUS 8'h0C
`define SUI_OFS_MEM_ADDR 8'h10
`define SUI_OFS_MEM_DATA 8'h14

// Status register field positions
`define SUI_ST_C 0
`define SUI_ST_DIGIT_CARRY 1
`define SUI_ST_Z 2
`define SUI_ST_OVERFLOW 3
`define SUI_ST_N 4
`define SUI_ST_BUSY 8
`define SUI_ST_ILLEGAL 9

// Opcode patterns
`define SUI_LIT_OPC 8'h08
`define SUI_FILE_OPC 6'h17

// Reset values
`define SUI_RST_INSTR 16'h0000
`define SUI_RST_BYTE 8'h00
`define SUI_RST_WORD 16'h0000

// One instruction cycle is four quarter phases of one clock each
`define SUI_QUARTERS 4

`endif

// ---- hw/sui_core.sv ----
`timescale 1ns/1ps
`include "sui_cfg.svh"

module sui_core #(
  parameter int BANK_W = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic busy,
  output sui_pkg::sui_flags_s flags,
  output logic [7:0] wreg_value
);
  import sui_pkg::*;

  // Data memory spans every bank: BANK_W bank bits above the 8-bit file address
  localparam int ADDR_W = BANK_W + 8;

  // Difference with its flags: {negative, overflow, zero, digit carry, carry, result}
  // Done one bit wider so the top bit is the borrow; carry is its inverse,
  // which is why a zero difference also reports carry set.
  // The low nibble is subtracted on its own for the digit carry.
  function automatic logic [12:0] sub8(input logic [7:0] minuend, input logic [7:0] subtrahend);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] res;
    logic carry;
    logic dcarry;
    logic ovf;
    full = {1'b0, minuend} - {1'b0, subtrahend};
    low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
    res = full[7:0];
    carry = ~full[8];
    dcarry = ~low[4];
    // Overflow: unlike operand signs and a result sign that left the minuend's
    ovf = (minuend[7] ^ subtrahend[7]) & (res[7] ^ minuend[7]);
    sub8 = {res[7], ovf, (res == 8'h00), dcarry, carry, res};
  endfunction

  // Data memory address from bank bit, bank select and file address
  // The access bank sends 0x00-0x7F to bank 0 and 0x80-0xFF to the last bank,
  // so both halves stay reachable without touching the bank select register.
  function automatic logic [ADDR_W-1:0] form_addr(input logic bank_bit,
                                                  input logic [BANK_W-1:0] bank_sel,
                                                  input logic [7:0] file_addr);
    logic [BANK_W-1:0] bank;
    if (bank_bit) begin
      bank = bank_sel;
    end else begin
      bank = file_addr[7] ? {BANK_W{1'b1}} : {BANK_W{1'b0}};
    end
    // Bank bits on top, file address below
    form_addr = {bank, file_addr};
  endfunction

  // The array registers its read data: a read issued in Q2 is ready in Q3.
  // Trade-off: one port only, so software memory writes are refused while busy.
  sui_mem_if #(.ADDR_W(ADDR_W)) mem_bus ();

  sui_data_mem #(
    .ADDR_W(ADDR_W)
  ) u_mem (
    .clk_sys(clk_sys),
    .port(mem_bus.mem)
  );

  // Sequencer state, latched instruction fields and software-visible registers
  // dest_file_r and daddr_r keep the Q1 decode for the write quarter
  sui_phase_e phase_r;
  sui_op_e op_r;
  sui_flags_s flags_r;
  sui_flags_s res_flags_r;
  logic [15:0] instr_r;
  logic [7:0] w_r;
  logic [BANK_W-1:0] bank_select_register_r;
  logic illegal_r;
  logic [ADDR_W-1:0] mem_addr_r;
  logic [ADDR_W-1:0] daddr_r;
  logic dest_file_r;
  logic [7:0] operand_r;
  logic [7:0] result_r;
  logic [15:0] rdata_r;
  logic rd_mem_r;

  // Instruction field decode
  // A file subtract carries d in bit 9 and a in bit 8; a literal one ignores them
  wire lit_hit = (instr_r[15:8] == `SUI_LIT_OPC);
  wire file_hit = (instr_r[15:10] == `SUI_FILE_OPC);
  wire dest_bit = instr_r[9];
  wire bank_bit = instr_r[8];
  wire [7:0] low_byte = instr_r[7:0];
  wire [ADDR_W-1:0] file_addr = form_addr(bank_bit, bank_select_register_r, low_byte);

  // Register port decode; software writes are ignored while an instruction runs.
  // Map: 0x00 instruction word (a write starts a cycle), 0x04 working register,
  // 0x08 bank select (low BANK_W bits), 0x0C status, 0x10 memory address,
  // 0x14 memory data (low byte). Status: carry, digit carry, zero, overflow
  // and negative in bits 0..4, busy in bit 8, sticky decode error in bit 9.
  // Refusing writes while busy keeps W, the bank and the memory port steady
  // under the instruction that uses them; software gets no error for it.
  wire idle = (phase_r == SUI_IDLE);
  wire wr_ok = reg_wr && idle;
  wire wr_instr = wr_ok && (reg_addr == `SUI_OFS_INSTR);
  wire wr_wreg = wr_ok && (reg_addr == `SUI_OFS_WREG);
  wire wr_bank_sel = wr_ok && (reg_addr == `SUI_OFS_BANK_SELECT_REGISTER);
  wire wr_status = wr_ok && (reg_addr == `SUI_OFS_STATUS);
  wire wr_maddr = wr_ok && (reg_addr == `SUI_OFS_MEM_ADDR);
  wire wr_mdata = wr_ok && (reg_addr == `SUI_OFS_MEM_DATA);
  wire rd_mdata = reg_rd && (reg_addr == `SUI_OFS_MEM_DATA);

  // Arithmetic on the operand fetched in the second quarter.
  // A file operand is read straight off the array's output register in Q3;
  // the port address falls back to the software address then, which is
  // harmless because the difference is captured at the end of Q3.
  wire [7:0] minuend = (op_r == SUI_OP_LIT) ? operand_r : mem_bus.rdata;
  wire [12:0] diff = sub8(minuend, w_r);

  // Quarter flags for the write phase
  // A literal subtract always lands in W, never in the file register
  wire q4_write = (phase_r == SUI_Q4);
  wire q4_to_w = q4_write && ((op_r == SUI_OP_LIT) || !dest_file_r);
  wire q4_to_f = q4_write && (op_r == SUI_OP_FILE) && dest_file_r;
  wire file_phase = (phase_r == SUI_Q2) || (phase_r == SUI_Q4);
  wire illegal_set = (phase_r == SUI_Q1) && !lit_hit && !file_hit;
  wire illegal_clr = wr_status && reg_wdata[`SUI_ST_ILLEGAL];

  // Memory port: the sequencer owns it in the read and write quarters
  // Outside Q2 and Q4 software owns the address through the memory address register
  // Software memory writes cannot meet a Q4 write: writes are refused while busy
  assign mem_bus.addr = file_phase ? daddr_r : mem_addr_r;
  assign mem_bus.we = q4_to_f || wr_mdata;
  assign mem_bus.wdata = q4_write ? result_r : reg_wdata[7:0];

  // Status word assembled from flags, busy and the sticky decode error
  // Unused bits read as zero and ignore writes; busy is read live from the phase
  wire [15:0] status_word = {6'h00, illegal_r, !idle, 3'h0,
                             flags_r.n, flags_r.overflow_flag, flags_r.z,
                             flags_r.digit_carry_flag, flags_r.c};
  wire [15:0] maddr_word = {{(16 - ADDR_W){1'b0}}, mem_addr_r};

  // Read selection; unmapped offsets read as zero
  // Memory data are not selected here: they come from the array's register
  logic [15:0] rd_sel;
  always_comb begin
    case (reg_addr)
      `SUI_OFS_INSTR: rd_sel = instr_r;
      `SUI_OFS_WREG: rd_sel = {8'h00, w_r};
      `SUI_OFS_BANK_SELECT_REGISTER: rd_sel = {{(16 - BANK_W){1'b0}}, bank_select_register_r};
      `SUI_OFS_STATUS: rd_sel = status_word;
      `SUI_OFS_MEM_ADDR: rd_sel = maddr_word;
      default: rd_sel = `SUI_RST_WORD;
    endcase
  end

  // Quarter sequencer: each quarter is one clock of clk_sys.
  // The write strobe cycle comes first; Q1 decodes, Q2 fetches the operand,
  // Q3 forms the difference, Q4 writes W or the file register with the flags.
  // An undecodable word leaves after Q1 so nothing is written for it;
  // busy stands four clocks for a subtract and one for a bad word.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phase_r <= SUI_IDLE;
    end else begin
      case (phase_r)
        SUI_IDLE: phase_r <= wr_instr ? SUI_Q1 : SUI_IDLE;
        SUI_Q1: phase_r <= (lit_hit || file_hit) ? SUI_Q2 : SUI_IDLE;
        SUI_Q2: phase_r <= SUI_Q3;
        SUI_Q3: phase_r <= SUI_Q4;
        SUI_Q4: phase_r <= SUI_IDLE;
        default: phase_r <= SUI_IDLE;
      endcase
    end
  end

  // First quarter: decode the instruction word
  // The bank is resolved here; the bank select cannot change while busy
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      op_r <= SUI_OP_NONE;
      dest_file_r <= 1'b0;
      daddr_r <= '0;
    end else if (phase_r == SUI_Q1) begin
      op_r <= lit_hit ? SUI_OP_LIT : (file_hit ? SUI_OP_FILE : SUI_OP_NONE);
      dest_file_r <= file_hit && dest_bit;
      daddr_r <= file_addr;
    end
  end

  // Second quarter: latch the literal; a file read is issued on the port
  // The literal is taken from the held instruction word, not the bus
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      operand_r <= `SUI_RST_BYTE;
    end else if (phase_r == SUI_Q2) begin
      operand_r <= low_byte;
    end
  end

  // Third quarter: hold difference and flags until the write quarter
  // Holding them lets Q4 write memory from a flop rather than the adder
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      result_r <= `SUI_RST_BYTE;
      res_flags_r <= '0;
    end else if (phase_r == SUI_Q3) begin
      result_r <= diff[7:0];
      res_flags_r <= diff[12:8];
    end
  end

  // Fourth quarter: flags land with the result
  // Software may load the five flags while idle, for instance to set up a test;
  // a load and a result cannot meet, since status writes are refused while busy
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags_r <= '0;
    end else if (q4_write) begin
      flags_r <= res_flags_r;
    end else if (wr_status) begin
      flags_r <= reg_wdata[4:0];
    end
  end

  // Working register: results from the write quarter, software loads when idle
  // The two sources never meet: software writes are refused while busy
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      w_r <= `SUI_RST_BYTE;
    end else if (q4_to_w) begin
      w_r <= result_r;
    end else if (wr_wreg) begin
      w_r <= reg_wdata[7:0];
    end
  end

  // Software-loaded registers; a write to the instruction offset starts a cycle
  // Bank select and memory address keep their value across instructions
  // The data memory itself has no reset; its contents are unknown until written
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      instr_r <= `SUI_RST_INSTR;
      bank_select_register_r <= '0;
      mem_addr_r <= '0;
    end else begin
      if (wr_instr) begin
        instr_r <= reg_wdata;
      end
      if (wr_bank_sel) begin
        bank_select_register_r <= reg_wdata[BANK_W-1:0];
      end
      if (wr_maddr) begin
        mem_addr_r <= reg_wdata[ADDR_W-1:0];
      end
    end
  end

  // Sticky decode error; a new error beats a clear in the same cycle
  // Clears are refused while busy today, but set still wins if that changes
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= illegal_set || (illegal_r && !illegal_clr);
    end
  end

  // Read data stand one cycle after the strobe
  // Other cycles read as zero so a stale value never looks like fresh data
  // Reads are never refused; a memory read in Q2 or Q4 shows the sequencer's address
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_r <= `SUI_RST_WORD;
      rd_mem_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rd_sel : `SUI_RST_WORD;
      rd_mem_r <= rd_mdata;
    end
  end

  // Memory data come from the array's own output register
  // No extra flop: the array's register already gives the one-cycle latency
  assign reg_rdata = rd_mem_r ? {8'h00, mem_bus.rdata} : rdata_r;
  assign busy = !idle;
  assign flags = flags_r;
  assign wreg_value = w_r;
endmodule // sui_core

// ---- hw/sui_data_mem.sv ----
`timescale 1ns/1ps

// Single-port data memory; read data leave through a register
module sui_data_mem #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  sui_mem_if.mem port
);
  logic [7:0] mem_r [0:(1<<ADDR_W)-1];
  logic [7:0] rdata_r;

  // Read-before-write: a write shows on the next read, not this one
  always_ff @(posedge clk_sys) begin
    if (port.we) begin
      mem_r[port.addr] <= port.wdata;
    end
    rdata_r <= mem_r[port.addr];
  end

  assign port.rdata = rdata_r;
endmodule // sui_data_mem

// ---- hw/sui_mem_if.sv ----
`timescale 1ns/1ps

// Data memory port between the sequencer and the memory array
interface sui_mem_if #(
  parameter int ADDR_W = 12
);
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;

  modport core (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

// ---- hw/sui_pkg.sv ----
package sui_pkg;

  // Quarter phases of one instruction cycle
  typedef enum logic [2:0] {
    SUI_IDLE,
    SUI_Q1,
    SUI_Q2,
    SUI_Q3,
    SUI_Q4
  } sui_phase_e;

  // Decoded instruction kind
  typedef enum logic [1:0] {
    SUI_OP_NONE,
    SUI_OP_LIT,
    SUI_OP_FILE
  } sui_op_e;

  // Arithmetic status flags
  typedef struct packed {
    logic n;
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } sui_flags_s;

endpackage

// ---- test/sui_core_chk.sv ----
`timescale 1ns/1ps

module sui_core_chk #(
  parameter int BANK_W = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic busy,
  input wire sui_pkg::sui_flags_s flags,
  input wire logic [7:0] wreg_value
);
  import sui_pkg::*;

  // Starts that an idle core must accept
  wire go = reg_wr && reg_addr == 8'h00 && !busy;
  wire lit_go = go && reg_wdata[15:8] == 8'h08;
  wire file_go = go && reg_wdata[15:10] == 6'h17;
  wire file_to_f = file_go && reg_wdata[9];

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  lit_cycle_a: assert property (lit_go |=> busy[*4] ##1 !busy)
    else $error("literal subtract not four quarters");
  file_cycle_a: assert property (file_go |=> busy[*4] ##1 !busy)
    else $error("file subtract not four quarters");
  lit_diff_a: assert property ($past(lit_go, 5) |->
    wreg_value == $past(reg_wdata[7:0], 5) - $past(wreg_value, 5))
    else $error("literal difference wrong");
  lit_flags_a: assert property ($past(lit_go, 5) |->
    flags.c == ($past(reg_wdata[7:0], 5) >= $past(wreg_value, 5))
    && flags.z == (wreg_value == 8'h00) && flags.n == wreg_value[7])
    else $error("literal flags wrong");
  lit_dc_a: assert property ($past(lit_go, 5) |->
    flags.digit_carry_flag == ($past(reg_wdata[3:0], 5) >= $past(wreg_value[3:0], 5)))
    else $error("literal digit carry wrong");
  file_keep_a: assert property ($past(file_to_f, 5) |->
    wreg_value == $past(wreg_value, 5))
    else $error("working register moved on file write");
  wreg_hold_a: assert property (busy ##1 busy |-> $stable(wreg_value))
    else $error("working register moved mid instruction");
  wreg_write_a: assert property (reg_wr && reg_addr == 8'h04 && !busy |=>
    wreg_value == $past(reg_wdata[7:0]))
    else $error("working register write lost");
  status_rd_a: assert property (reg_rd && reg_addr == 8'h0C |=>
    reg_rdata[4:0] == $past(flags) && reg_rdata[8] == $past(busy))
    else $error("status read wrong");
endmodule // sui_core_chk

bind sui_core sui_core_chk #(.BANK_W(BANK_W)) sui_core_chk_inst (.clk_sys(clk_sys),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy), .flags(flags),
  .wreg_value(wreg_value));

// ---- test/sui_core_tb_top.sv ----
`timescale 1ns/1ps

module sui_core_tb_top;
  import sui_pkg::*;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic busy;
  sui_flags_s flags;
  logic [7:0] wreg_value;
  logic [15:0] exp_q[$];
  logic rd_d = 1'b0;
  int err_total = 0;
  int compares = 0;
  integer seed = 32'hff0a;
  logic [7:0] k, w, v, f;
  logic [3:0] b;
  logic [11:0] ad;

  sui_core sui_core_inst (
    .clk_sys(clk_sys),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .busy(busy),
    .flags(flags),
    .wreg_value(wreg_value)
  );

  // 125 MHz system clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Expected flags {negative,overflow,zero,digit carry,carry}; carry means no borrow
  function automatic logic [4:0] fl(input logic [7:0] a, input logic [7:0] s);
    logic [7:0] r;
    r = a - s;
    return {r[7], a[7] != s[7] && r[7] != a[7], r == 8'h00, a[3:0] >= s[3:0], a >= s};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compares=%0d errors=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One strobe, then an idle edge so no strobe is set twice in one step
  task automatic acc(input logic wn, input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wn;
    reg_rd <= !wn;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 16'h0000);
  endtask

  // Start an instruction, optionally poke W while busy, wait for idle
  task automatic run(input logic [15:0] ins, input logic poke);
    int n;
    n = 0;
    acc(1'b1, 8'h00, ins);
    if (poke)
      acc(1'b1, 8'h04, 16'h00AA);
    // Busy read at an edge is the value of the cycle just ended
    while (busy !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 20) begin
      err_total++;
      wrap_up();
    end
  endtask

  // Read data stand one cycle after the strobe; compare with oldest note
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d && exp_q.size() > 0)
      check(reg_rdata, exp_q.pop_front());
  end

  // Hang guard
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(8'h0C, 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h20, 16'h0000);
    // Literal subtract: three fixed cases, then random ones
    for (int i = 0; i < 12; i++) begin
      k = (i < 3) ? 8'h02 : 8'($random(seed));
      w = (i < 3) ? 8'(i + 1) : 8'($random(seed));
      acc(1'b1, 8'h04, {8'h00, w});
      run({8'h08, k}, i == 3);
      rd(8'h04, {8'h00, k - w});
      rd(8'h0C, {11'h000, fl(k, w)});
    end
    // File subtract over every destination and bank choice
    for (int i = 0; i < 16; i++) begin
      f = {i[2], 7'($random(seed))};
      b = 4'($random(seed));
      w = 8'($random(seed));
      v = (i == 5) ? w : 8'($random(seed));
      ad = i[1] ? {b, f} : {f[7] ? 4'hF : 4'h0, f};
      acc(1'b1, 8'h08, {12'h000, b});
      acc(1'b1, 8'h04, {8'h00, w});
      acc(1'b1, 8'h10, {4'h0, ad});
      acc(1'b1, 8'h14, {8'h00, v});
      rd(8'h08, {12'h000, b});
      rd(8'h10, {4'h0, ad});
      run({6'h17, i[0], i[1], f}, 1'b0);
      rd(8'h04, {8'h00, i[0] ? w : v - w});
      acc(1'b1, 8'h10, {4'h0, ad});
      rd(8'h14, {8'h00, i[0] ? v - w : v});
      rd(8'h0C, {11'h000, fl(v, w)});
    end
    // Unknown opcode raises the sticky flag; writing one clears it
    run(16'hFFFF, 1'b0);
    rd(8'h00, 16'hFFFF);
    rd(8'h0C, {6'h00, 1'b1, 4'h0, fl(v, w)});
    acc(1'b1, 8'h0C, 16'h0200);
    rd(8'h0C, 16'h0000);
    repeat (3) @(posedge clk_sys);
    wrap_up();
  end
endmodule // sui_core_tb_top
